// [logic/wiper_ctrl_pkg.sv]
// Shared constants, types and encodings for the serial wiper register controller
package wiper_ctrl_pkg;

  // Clock and timing
  localparam int          CLK_PERIOD_NS      = 10;
  localparam int          NV_WRITE_TIME_NS   = 10_000_000;  // Longest stored-register write, 10 ms
  localparam int          NV_WRITE_CYCLES    = NV_WRITE_TIME_NS / CLK_PERIOD_NS;  // Longest time rounds down
  localparam int          NV_CNT_W           = 20;
  localparam int          WIPER_SETTLE_NS    = 1000;  // Settling delay of the wiper after a recall
  localparam int          WIPER_SETTLE_CYCLES = (WIPER_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SETTLE_CNT_W       = 8;

  // Register geometry
  localparam int          POS_W              = 10;
  localparam int          TAP_COUNT          = 1024;
  localparam int          STORED_COUNT       = 4;
  localparam logic [9:0]  STORED_RESET       = 10'h000;
  localparam logic [9:0]  WIPER_RESET        = 10'h000;
  localparam logic [1023:0] TAP_RESET        = 1024'h1;

  // Identification byte layout
  localparam int          ID_TYPE_MSB        = 7;
  localparam int          ID_TYPE_LSB        = 4;
  localparam int          ID_ADDR_BIT        = 1;
  localparam int          ID_DIR_BIT         = 0;
  localparam logic [1:0]  ID_FIXED_BITS      = 2'h0;  // Bits 3:2 of the identification byte

  // Instruction byte layout
  localparam int          INS_OPC_MSB        = 7;
  localparam int          INS_OPC_LSB        = 5;
  localparam int          INS_ZERO_BIT       = 4;
  localparam int          INS_SEL_HIGH       = 3;
  localparam int          INS_SEL_LOW        = 2;
  localparam logic [1:0]  INS_TAIL_PLAIN     = 2'h0;
  localparam logic [1:0]  INS_TAIL_STATUS    = 2'h1;

  // Opcodes, qualified by the direction bit
  localparam logic [2:0]  OPC_WIPER_RD       = 3'h4;  // Direction read
  localparam logic [2:0]  OPC_WIPER_WR       = 3'h5;  // Direction write
  localparam logic [2:0]  OPC_STORED_RD      = 3'h5;  // Direction read
  localparam logic [2:0]  OPC_STORED_WR      = 3'h6;  // Direction write
  localparam logic [2:0]  OPC_RECALL         = 3'h6;  // Direction read, stored to wiper
  localparam logic [2:0]  OPC_SAVE           = 3'h7;  // Direction write, wiper to stored
  localparam logic [2:0]  OPC_STATUS_RD      = 3'h2;  // Direction read

  // Frame bit counts
  localparam logic [3:0]  BYTE_LAST_BIT      = 4'h7;
  localparam logic [3:0]  DATA_LAST_BIT      = 4'hf;

  // Pin synchroniser reset levels: select and pause idle high
  localparam logic [5:0]  PIN_SYNC_RESET     = 6'h30;

  // Decoded command
  typedef enum logic [2:0] {
    OP_NONE           = 3'h0,
    OP_WIPER_RD       = 3'h1,
    OP_WIPER_WR       = 3'h2,
    OP_STORED_RD      = 3'h3,
    OP_STORED_WR      = 3'h4,
    OP_RECALL         = 3'h5,
    OP_SAVE           = 3'h6,
    OP_STATUS_RD      = 3'h7
  } op_t;

  typedef struct packed {
    op_t        op;
    logic [1:0] sel;
  } cmd_t;

  // Sampled pin group, in synchroniser order
  typedef struct packed {
    logic cs_n;
    logic hold_n;
    logic wp_n;
    logic addr;
    logic sck;
    logic si;
  } pins_t;

  // Frame sequencer, Gray coded along ID, instruction, data, done
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_ID     = 3'h1,
    ST_INSTR  = 3'h3,
    ST_DATA   = 3'h2,
    ST_DONE   = 3'h6,
    ST_IGNORE = 3'h7
  } state_t;

endpackage

// [logic/tap_decoder.sv]
// One-hot decoder from wiper position to tap switch enables
`timescale 1ns/10ps
module tap_decoder
  import wiper_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 reset_in,
  // Position in, switch enables out
  input  wire logic [POS_W-1:0]     position_in,
  output logic      [TAP_COUNT-1:0] tap_select_out
);

  logic [TAP_COUNT-1:0] tap_d;

  // exactly one tap
  // Each switch compares against its own index, so only one can ever match
  for (genvar i = 0; i < TAP_COUNT; i++) begin : g_tap
    assign tap_d[i] = (position_in == POS_W'(i));
  end

  // Registered so that decode glitches never reach the switches
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      tap_select_out <= TAP_RESET;
    end else begin
      tap_select_out <= tap_d;
    end
  end

endmodule

// [logic/spi_wiper_register_control.sv]
// Serial slave that manages the wiper position, stored positions and write status
//
// Summary of operation
// - Sample serial input on rising serial clock
// - Serial output driven only for read data
// - Wiper position decodes to exactly one tap
// - Wiper changes by write, recall or power-up
// - Four ten-bit stored positions, readable and writable
// - Stored-register write finishes within ten ms
// - Pending flag high exactly during stored write
// - First byte carries and checks device type
// - Execute only when address bit matches pin
// - Last identification bit selects read or write
// - Instruction byte: opcode, two select bits, fixed
// - Wiper read and write opcodes
// - Stored register read and write opcodes
// - Transfer opcodes in both directions
// - Status read returns pending flag last bit
// - Data commands carry two data bytes
// - Transfers end after the instruction byte
// - Recall settles, save takes write time
// - Save starts on select rising after sequence
// - Read bits shift out on falling clock
// - Lock low refuses stored-register writes
// - Pause freezes sequence while clock low
// - Deselected output floats; first select falling needed (a select held low through reset counts as one)
`timescale 1ns/10ps
module spi_wiper_register_control
  import wiper_ctrl_pkg::*;
#(
  parameter logic [3:0] DEVICE_TYPE_CODE = 4'ha,  // Arbitrary value, set to the product's type code
  parameter int         NV_WRITE_CYCLES_P = NV_WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 reset_in,
  // Serial link pins
  input  wire logic                 cs_n_in,
  input  wire logic                 sck_in,
  input  wire logic                 si_in,
  input  wire logic                 bus_pause_n_in,
  input  wire logic                 nv_write_lock_n_in,
  input  wire logic                 slave_addr_pin_in,
  output logic                      so_out,
  output logic                      so_oe_out,
  // Resistor array side
  output logic      [TAP_COUNT-1:0] tap_select_out,
  output logic      [POS_W-1:0]     wiper_position_out,
  output logic                      nv_write_pending_out
);

  // Decode of the instruction byte, qualified by the captured direction
  function automatic cmd_t decode_cmd(input logic rw, input logic [7:0] ins);
    cmd_t       c;
    logic [2:0] opc;
    logic       plain;
    logic       sel_zero;
    c        = '{op: OP_NONE, sel: ins[INS_SEL_HIGH:INS_SEL_LOW]};
    opc      = ins[INS_OPC_MSB:INS_OPC_LSB];
    plain    = !ins[INS_ZERO_BIT] && (ins[1:0] == INS_TAIL_PLAIN);
    sel_zero = (c.sel == 2'h0);
    if (rw) begin
      if (opc == OPC_WIPER_RD && plain && sel_zero) c.op = OP_WIPER_RD;
      if (opc == OPC_STORED_RD && plain) c.op = OP_STORED_RD;
      if (opc == OPC_RECALL && plain) c.op = OP_RECALL;
      if (opc == OPC_STATUS_RD && !ins[INS_ZERO_BIT] && sel_zero && ins[1:0] == INS_TAIL_STATUS) begin
        c.op = OP_STATUS_RD;
      end
    end else begin
      if (opc == OPC_WIPER_WR && plain && sel_zero) c.op = OP_WIPER_WR;
      if (opc == OPC_STORED_WR && plain) c.op = OP_STORED_WR;
      if (opc == OPC_SAVE && plain) c.op = OP_SAVE;
    end
    return c;
  endfunction

  localparam logic [NV_CNT_W-1:0]     NV_LAST     = NV_CNT_W'(NV_WRITE_CYCLES_P - 1);
  localparam logic [SETTLE_CNT_W-1:0] SETTLE_LAST = SETTLE_CNT_W'(WIPER_SETTLE_CYCLES - 1);

  pins_t                    pins_raw;
  pins_t                    meta_q;
  pins_t                    sync_q;
  logic                     sck_prev_q;
  logic                     cs_prev_q;
  state_t                   state_q;
  logic [3:0]               bit_cnt_q;
  logic                     rw_q;
  cmd_t                     cmd_q;
  logic [15:0]              in_shift_q;
  logic [15:0]              out_shift_q;
  logic                     so_q;
  logic [POS_W-1:0]         wr_data_q;
  logic [POS_W-1:0]         wiper_q;
  logic [POS_W-1:0]         stored_q [STORED_COUNT];
  logic                     recall_q;
  logic                     nv_busy_q;
  logic [NV_CNT_W-1:0]      nv_cnt_q;
  logic [POS_W-1:0]         nv_data_q;
  logic [1:0]               nv_sel_q;
  logic                     settle_busy_q;
  logic [SETTLE_CNT_W-1:0]  settle_cnt_q;
  logic [POS_W-1:0]         settle_val_q;

  logic                     active;
  logic                     sck_rise;
  logic                     sck_fall;
  logic                     cs_fall;
  logic                     cs_rise;
  logic [7:0]               byte_in;
  logic [15:0]              word_in;
  logic                     last_bit;
  logic                     id_ok;
  cmd_t                     cmd_next;
  logic                     is_read;
  logic                     execute;
  logic                     nv_start;
  logic [POS_W-1:0]         nv_src;
  logic                     nv_done;
  logic                     settle_done;
  logic [15:0]              read_word;

  // Every pin crosses two flops before any logic looks at it
  assign pins_raw = '{cs_n: cs_n_in, hold_n: bus_pause_n_in, wp_n: nv_write_lock_n_in,
                      addr: slave_addr_pin_in, sck: sck_in, si: si_in};

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_q <= PIN_SYNC_RESET;
      sync_q <= PIN_SYNC_RESET;
    end else begin
      meta_q <= pins_raw;
      sync_q <= meta_q;
    end
  end

  // Edge history; select starts high so a select held low through reset counts as a falling edge
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end else begin
      sck_prev_q <= sync_q.sck;
      cs_prev_q  <= sync_q.cs_n;
    end
  end

  // pause freezes clocking
  // Clock edges are ignored while paused, so the sequence state simply holds
  assign active   = !sync_q.cs_n && sync_q.hold_n;
  assign sck_rise = active && sync_q.sck && !sck_prev_q;
  assign sck_fall = active && !sync_q.sck && sck_prev_q;
  assign cs_fall  = !sync_q.cs_n && cs_prev_q;
  assign cs_rise  = sync_q.cs_n && !cs_prev_q;

  assign byte_in  = {in_shift_q[6:0], sync_q.si};
  assign word_in  = {in_shift_q[14:0], sync_q.si};
  assign last_bit = (bit_cnt_q == ((state_q == ST_DATA) ? DATA_LAST_BIT : BYTE_LAST_BIT));

  assign id_ok    = (byte_in[ID_TYPE_MSB:ID_TYPE_LSB] == DEVICE_TYPE_CODE) &&
                    (byte_in[3:2] == ID_FIXED_BITS) &&
                    (byte_in[ID_ADDR_BIT] == sync_q.addr);
  assign cmd_next = decode_cmd(rw_q, byte_in);
  assign is_read  = (cmd_q.op == OP_WIPER_RD) || (cmd_q.op == OP_STORED_RD) || (cmd_q.op == OP_STATUS_RD);

  // Frame sequencer
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      rw_q      <= 1'b0;
      cmd_q     <= '{op: OP_NONE, sel: 2'h0};
    end else if (cs_rise) begin
      state_q <= ST_IDLE;
    end else if (cs_fall) begin
      state_q   <= ST_ID;
      bit_cnt_q <= 4'h0;
      cmd_q     <= '{op: OP_NONE, sel: 2'h0};
    end else if (sck_rise) begin
      unique case (state_q)
        ST_ID: begin
          if (last_bit) begin
            rw_q      <= byte_in[ID_DIR_BIT];
            state_q   <= id_ok ? ST_INSTR : ST_IGNORE;
            bit_cnt_q <= 4'h0;
          end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
        end
        ST_INSTR: begin
          if (last_bit) begin
            cmd_q     <= cmd_next;
            bit_cnt_q <= 4'h0;
            if (cmd_next.op == OP_NONE) begin
              state_q <= ST_IGNORE;
            end else if (cmd_next.op == OP_RECALL || cmd_next.op == OP_SAVE) begin
              state_q <= ST_DONE;
            end else begin
              state_q <= ST_DATA;
            end
          end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
        end
        ST_DATA: begin
          if (last_bit) begin
            state_q <= ST_DONE;
          end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
        end
        ST_IDLE, ST_DONE, ST_IGNORE: begin
          state_q <= state_q;  // Extra clocks are ignored until select rises
        end
      endcase
    end
  end

  // Input shifter and captured write data
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      in_shift_q <= 16'h0000;
      wr_data_q  <= WIPER_RESET;
    end else if (cs_fall) begin
      in_shift_q <= 16'h0000;
    end else if (sck_rise) begin
      in_shift_q <= word_in;
      if (state_q == ST_DATA && last_bit) begin
        wr_data_q <= word_in[POS_W-1:0];
      end
    end
  end

  // Read word is picked at the end of the instruction byte, so the first bit is ready for the next fall
  always_comb begin
    read_word = 16'h0000;
    unique case (cmd_next.op)
      OP_WIPER_RD:  read_word = {6'h00, wiper_q};
      OP_STORED_RD: read_word = {6'h00, stored_q[cmd_next.sel]};
      OP_STATUS_RD: read_word = {15'h0000, nv_busy_q};
      OP_NONE, OP_WIPER_WR, OP_STORED_WR, OP_RECALL, OP_SAVE: read_word = 16'h0000;
    endcase
  end

  // Output shifter
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      out_shift_q <= 16'h0000;
      so_q        <= 1'b0;
    end else if (sck_rise && state_q == ST_INSTR && last_bit) begin
      out_shift_q <= read_word;
    end else if (sck_fall && state_q == ST_DATA) begin
      so_q        <= out_shift_q[15];
      out_shift_q <= {out_shift_q[14:0], 1'b0};
    end
  end

  assign so_out    = so_q;
  assign so_oe_out = active && (state_q == ST_DATA) && is_read;

  // act on select rising
  // Only a frame that reached the done state counts as a complete sequence
  assign execute  = cs_rise && (state_q == ST_DONE);
  // lock refuses stored writes
  // A save already running is not restarted; the new request is dropped
  assign nv_start = execute && sync_q.wp_n && !nv_busy_q &&
                    (cmd_q.op == OP_STORED_WR || cmd_q.op == OP_SAVE);
  assign nv_src   = (cmd_q.op == OP_STORED_WR) ? wr_data_q : wiper_q;
  assign nv_done  = nv_busy_q && (nv_cnt_q == NV_LAST);

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      nv_busy_q <= 1'b0;
      nv_cnt_q  <= '0;
      nv_data_q <= STORED_RESET;
      nv_sel_q  <= 2'h0;
    end else if (nv_start) begin
      nv_busy_q <= 1'b1;
      nv_cnt_q  <= '0;
      nv_data_q <= nv_src;
      nv_sel_q  <= cmd_q.sel;
    end else if (nv_done) begin
      nv_busy_q <= 1'b0;
    end else if (nv_busy_q) begin
      nv_cnt_q <= nv_cnt_q + NV_CNT_W'(1);
    end
  end

  // four stored positions
  // Contents commit at the end of the write cycle, as the cell would
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < STORED_COUNT; i++) begin
        stored_q[i] <= STORED_RESET;
      end
    end else if (nv_done) begin
      stored_q[nv_sel_q] <= nv_data_q;
    end
  end

  assign settle_done = settle_busy_q && (settle_cnt_q == SETTLE_LAST);

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      settle_busy_q <= 1'b0;
      settle_cnt_q  <= '0;
      settle_val_q  <= WIPER_RESET;
    end else if (execute && cmd_q.op == OP_RECALL) begin
      settle_busy_q <= 1'b1;
      settle_cnt_q  <= '0;
      settle_val_q  <= stored_q[cmd_q.sel];
    end else if (settle_done) begin
      settle_busy_q <= 1'b0;
    end else if (settle_busy_q) begin
      settle_cnt_q <= settle_cnt_q + SETTLE_CNT_W'(1);
    end
  end

  // wiper update sources
  // Power-up recall of the default slot runs once, on the first edge after reset
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wiper_q  <= WIPER_RESET;
      recall_q <= 1'b1;
    end else begin
      recall_q <= 1'b0;
      if (recall_q) begin
        wiper_q <= stored_q[0];
      end else if (execute && cmd_q.op == OP_WIPER_WR) begin
        wiper_q <= wr_data_q;
      end else if (settle_done) begin
        wiper_q <= settle_val_q;
      end
    end
  end

  assign wiper_position_out   = wiper_q;
  assign nv_write_pending_out = nv_busy_q;

  tap_decoder u_tap_decoder (
    .clk_in         (clk_in),
    .reset_in       (reset_in),
    .position_in    (wiper_q),
    .tap_select_out (tap_select_out)
  );

endmodule

// [verification/spi_wiper_props.sv]
// Port-level checker for the serial wiper register controller
`timescale 1ns/10ps
module spi_wiper_props
  import wiper_ctrl_pkg::*;
#(
  parameter int NV_WRITE_CYCLES_P = 50
) (
  // Clock and reset
  input wire logic                 clk_in,
  input wire logic                 reset_in,
  // Serial pins
  input wire logic                 cs_n_in,
  input wire logic                 sck_in,
  input wire logic                 bus_pause_n_in,
  input wire logic                 nv_write_lock_n_in,
  input wire logic                 so_out,
  input wire logic                 so_oe_out,
  // Resistor array side
  input wire logic [TAP_COUNT-1:0] tap_select_out,
  input wire logic [POS_W-1:0]     wiper_position_out,
  input wire logic                 nv_write_pending_out
);
  int nv_len_q;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // Length of the running write cycle, so its span needs no long repetition
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) nv_len_q <= 0;
    else nv_len_q <= nv_write_pending_out ? nv_len_q + 1 : 0;
  end

  sequence s_cs_idle; cs_n_in [*4]; endsequence
  sequence s_paused; !bus_pause_n_in [*4]; endsequence
  property p_one_tap; $onehot(tap_select_out); endproperty
  property p_tap_follow; tap_select_out == (TAP_RESET << $past(wiper_position_out)); endproperty
  property p_cs_float; s_cs_idle |-> !so_oe_out; endproperty
  property p_pause_float; s_paused |-> !so_oe_out; endproperty
  property p_pend_len; $fell(nv_write_pending_out) |-> nv_len_q == NV_WRITE_CYCLES_P; endproperty
  property p_pend_max; nv_len_q <= NV_WRITE_CYCLES_P; endproperty
  property p_pend_start; $rose(nv_write_pending_out) |-> $past(cs_n_in, 2); endproperty
  property p_lock; $rose(nv_write_pending_out) |-> $past(nv_write_lock_n_in, 2); endproperty
  property p_so_fall; $changed(so_out) && so_oe_out |-> !$past(sck_in, 2); endproperty

  a_one_tap: assert property (p_one_tap) else $error("tap select not one-hot");
  a_tap_follow: assert property (p_tap_follow) else $error("tap select not from wiper");
  a_cs_float: assert property (p_cs_float) else $error("output driven while deselected");
  a_pause_float: assert property (p_pause_float) else $error("output driven while paused");
  a_pend_len: assert property (p_pend_len) else $error("write cycle length wrong");
  a_pend_max: assert property (p_pend_max) else $error("write cycle too long");
  a_pend_start: assert property (p_pend_start) else $error("write started inside a frame");
  a_lock: assert property (p_lock) else $error("write started while locked");
  a_so_fall: assert property (p_so_fall) else $error("output bit moved off falling clock");
endmodule

bind spi_wiper_register_control spi_wiper_props #(.NV_WRITE_CYCLES_P(NV_WRITE_CYCLES_P)) i_spi_wiper_props (
  .clk_in, .reset_in, .cs_n_in, .sck_in, .bus_pause_n_in, .nv_write_lock_n_in, .so_out, .so_oe_out,
  .tap_select_out, .wiper_position_out, .nv_write_pending_out);

// [verification/spi_host_model.sv]
// Host serial master that frames commands for the wiper controller
`timescale 1ns/10ps
module spi_host_model (
  // Clock
  input  wire logic clk_in,
  // Lines from the device
  input  wire logic so_in,
  input  wire logic so_oe_in,
  // Lines to the device
  output logic      cs_n_out,
  output logic      sck_out,
  output logic      si_out,
  output logic      bus_pause_n_out
);
  logic so_last = 1'b0;
  logic so_line;

  // A floating line shows the inverse of its last level, never a stale copy
  assign so_line = so_oe_in ? so_in : ~so_last;
  always @(posedge clk_in) begin
    if (so_oe_in) so_last <= so_in;
  end

  // Idle levels: deselected, clock low and still, no pause
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
    bus_pause_n_out = 1'b1;
  end

  task automatic frame(input logic [31:0] tx, input int nbits, input bit pz, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    #103;
    for (int i = 0; i < nbits; i++) begin
      si_out = tx[31-i];
      #62.5;
      sck_out = 1'b1;
      rx = {rx[14:0], so_line};
      #62.5;
      sck_out = 1'b0;
      if (pz && i == 20) begin
        #20 bus_pause_n_out = 1'b0;
        #300 bus_pause_n_out = 1'b1;
        #20;
      end
    end
    #62.5;
    @(posedge clk_in);
    cs_n_out <= 1'b1;
  endtask
endmodule

// [verification/tb_spi_wiper_register_control.sv]
// Self-checking bench for the serial wiper register controller
`timescale 1ns/10ps
module tb_spi_wiper_register_control
  import wiper_ctrl_pkg::*;
;
  localparam int         NV = 2000;
  localparam logic [3:0] TYPE = 4'h9;  // Arbitrary type code
  logic                 clk_in = 0, reset_in = 1, lock_n = 1, addr = 0, oe_seen = 0;
  logic                 cs_n, sck, si, pause_n, so, so_oe, pend;
  logic [TAP_COUNT-1:0] taps;
  logic [POS_W-1:0]     wiper, v;
  logic [POS_W-1:0]     sv [4];
  logic [15:0]          rx;
  int                   errors = 0, checked = 0, run_q = 0, last_len = 0;

  always #5 clk_in = ~clk_in;

  spi_wiper_register_control #(.DEVICE_TYPE_CODE(TYPE), .NV_WRITE_CYCLES_P(NV)) i_spi_wiper_register_control (
    .clk_in, .reset_in, .cs_n_in(cs_n), .sck_in(sck), .si_in(si), .bus_pause_n_in(pause_n),
    .nv_write_lock_n_in(lock_n), .slave_addr_pin_in(addr), .so_out(so), .so_oe_out(so_oe),
    .tap_select_out(taps), .wiper_position_out(wiper), .nv_write_pending_out(pend));
  spi_host_model i_spi_host_model (.clk_in, .so_in(so), .so_oe_in(so_oe), .cs_n_out(cs_n), .sck_out(sck),
    .si_out(si), .bus_pause_n_out(pause_n));

  // Length of each write cycle and any sighting of the output enable
  always @(posedge clk_in) begin
    if (so_oe) oe_seen <= 1'b1;
    if (pend) run_q <= run_q + 1;
    else if (run_q != 0) begin
      last_len <= run_q;
      run_q <= 0;
    end
  end

  task automatic final_report();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Identification byte; bad[0] flips the address bit, bad[1] the type code
  function automatic logic [7:0] idb(input logic dir, input logic [1:0] bad);
    return {TYPE ^ {4{bad[1]}}, ID_FIXED_BITS, addr ^ bad[0], dir};
  endfunction

  function automatic logic [7:0] insb(input logic [2:0] opc, input logic [1:0] sel, input logic [1:0] tail);
    return {opc, 1'b0, sel, tail};
  endfunction

  task automatic xfer(input logic [7:0] id, input logic [7:0] ins, input logic [9:0] val, input int nbits,
                      input bit pz);
    oe_seen = 1'b0;
    i_spi_host_model.frame({id, ins, 6'h00, val}, nbits, pz, rx);
    repeat (12) @(posedge clk_in);
  endtask

  // Bounded wait for the write cycle to end
  task automatic wait_idle();
    for (int i = 0; i < NV + 100 && pend !== 1'b0; i++) @(posedge clk_in);
    repeat (2) @(posedge clk_in);
  endtask

  initial begin
    void'($urandom(87));
    addr = 1'($urandom);
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("wiper reset", 0, wiper);
    chk("taps reset", 1, taps === TAP_RESET);
    // Wiper writes at both range ends and random, the last write and read paused, each read back
    for (int k = 0; k < 4; k++) begin
      v = k == 0 ? 10'h3ff : k == 1 ? 10'h000 : 10'($urandom);
      xfer(idb(0, 0), insb(OPC_WIPER_WR, 0, 0), v, 32, k == 3);
      chk("wiper write", v, wiper);
      chk("one tap", 1, taps === (TAP_RESET << v));
      xfer(idb(1, 0), insb(OPC_WIPER_RD, 0, 0), ~v, 32, k == 3);
      chk("wiper read", {6'h00, v}, rx);
    end
    // Stored writes to all slots, status while busy and after
    for (int s = 0; s < 4; s++) begin
      sv[s] = 10'($urandom);
      xfer(idb(0, 0), insb(OPC_STORED_WR, 2'(s), 0), sv[s], 32, 0);
      chk("pending", 1, pend);
      xfer(idb(1, 0), insb(OPC_STATUS_RD, 0, INS_TAIL_STATUS), 0, 32, 0);
      chk("status busy", 1, rx);
      wait_idle();
      chk("write length", NV, last_len);
      xfer(idb(1, 0), insb(OPC_STATUS_RD, 0, INS_TAIL_STATUS), 0, 32, 0);
      chk("status idle", 0, rx);
    end
    for (int s = 0; s < 4; s++) begin
      xfer(idb(1, 0), insb(OPC_STORED_RD, 2'(s), 0), 0, 32, 0);
      chk("stored read", {6'h00, sv[s]}, rx);
    end
    // Save the wiper to slot 2, then recall slot 1 across its settling delay
    v = 10'($urandom);
    xfer(idb(0, 0), insb(OPC_WIPER_WR, 0, 0), v, 32, 0);
    xfer(idb(0, 0), insb(OPC_SAVE, 2'h2, 0), 0, 16, 0);
    chk("save pending", 1, pend);
    wait_idle();
    chk("save length", NV, last_len);
    xfer(idb(1, 0), insb(OPC_STORED_RD, 2'h2, 0), 0, 32, 0);
    chk("saved value", {6'h00, v}, rx);
    xfer(idb(1, 0), insb(OPC_RECALL, 2'h1, 0), 0, 16, 0);
    repeat (60) @(posedge clk_in);
    chk("recall settling", v, wiper);
    repeat (60) @(posedge clk_in);
    chk("recall", sv[1], wiper);
    // Lock refuses a stored write and a save
    lock_n <= 1'b0;
    xfer(idb(0, 0), insb(OPC_STORED_WR, 2'h3, 0), ~sv[3], 32, 0);
    xfer(idb(0, 0), insb(OPC_SAVE, 2'h3, 0), 0, 16, 0);
    chk("locked", 0, pend);
    lock_n <= 1'b1;
    xfer(idb(1, 0), insb(OPC_STORED_RD, 2'h3, 0), 0, 32, 0);
    chk("locked value", {6'h00, sv[3]}, rx);
    // Refused frames: address, type code, select bits, cut short
    for (int k = 0; k < 4; k++) begin
      xfer(idb(0, k < 2 ? 2'(k + 1) : 2'h0), insb(OPC_WIPER_WR, 2'(k == 2), 0), ~sv[1], k == 3 ? 24 : 32, 0);
      chk("refused write", sv[1], wiper);
      xfer(idb(1, 2'(k % 2 + 1)), insb(OPC_WIPER_RD, 0, 0), 0, 32, 0);
      chk("floating", 0, oe_seen);
    end
    final_report();
  end

  // Watchdog well beyond the expected run of about 245 us, yet under the cycle budget
  initial begin
    #800_000;
    errors++;
    final_report();
  end
endmodule
